/* File: src/bsm_pkg.sv */
//------------------------------------------------------------
// Purpose: Shared constants and types of the boot mode select
// Assumes: 125 MHz system clock
// Notes:   Strap codes are read as {pin2, pin1, pin0}
//------------------------------------------------------------
package bsm_pkg;

	//------------------------------------------------------------
	// Timing
	//------------------------------------------------------------
	localparam int          CLK_MHZ           = 125;
	localparam int          STRAP_SETTLE_NS   = 1000;
	localparam int          STRAP_SETTLE_CYC  = (STRAP_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int          BREAK_TIME_US     = 100;
	localparam int unsigned BREAK_CYC         = BREAK_TIME_US * CLK_MHZ;
	localparam int          RESTORE_TIME_S    = 8;
	localparam int unsigned RESTORE_CYC       = RESTORE_TIME_S * CLK_MHZ * 1000000;

	//------------------------------------------------------------
	// Strap pins and codes
	//------------------------------------------------------------
	localparam int          STRAP_W                   = 3;
	localparam logic [2:0]  SERIAL_LOAD_CODE          = 3'h4;
	localparam logic [2:0]  RUN_TWO_WIRE_CODE         = 3'h1;
	localparam logic [2:0]  RUN_FOUR_WIRE_CODE        = 3'h0;
	localparam logic [2:0]  BREAK_QUALIFIED_LOAD_CODE = 3'h2;
	localparam logic [2:0]  FACTORY_RESTORE_CODE      = 3'h3;
	localparam logic [2:0]  STRAP_RESET_VAL           = 3'h0;

	//------------------------------------------------------------
	// Protected flash sector
	//------------------------------------------------------------
	localparam int          SECTOR_W       = 8;
	localparam logic [7:0]  FACTORY_SECTOR = 8'h00;

	//------------------------------------------------------------
	// Types
	//------------------------------------------------------------
	typedef enum logic [2:0] {
		FLOW_HOLD,
		FLOW_SERIAL_LOAD,
		FLOW_RUN_TWO_WIRE,
		FLOW_RUN_FOUR_WIRE,
		FLOW_RESTORE
	} bsm_flow_e;

	typedef enum logic [1:0] {
		RESTORE_NONE,
		RESTORE_PARAMS,
		RESTORE_IMAGE_PARAMS
	} bsm_restore_e;

endpackage

/* File: src/bsm_restore_if.sv */
//------------------------------------------------------------
// Purpose: Link between boot sequencer and restore engine
// Assumes: One clock domain
// Notes:   start is a one-cycle request, done a one-cycle answer
//------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
interface bsm_restore_if;
	import bsm_pkg::*;
	logic         start;
	logic         abort;
	bsm_restore_e kind;
	logic         busy;
	logic         done;
	logic         timeout;
	bsm_restore_e run_kind;

	modport ctl (output start, abort, kind, input busy, done, timeout, run_kind);
	modport eng (input start, abort, kind, output busy, done, timeout, run_kind);
endinterface
`default_nettype wire

/* File: src/bsm_sync.sv */
//------------------------------------------------------------
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Inputs are slow levels
// Notes:   First stage feeds only the second stage
//------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module bsm_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_sys_rst,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_q;

	// Two stages, cleared to zero
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			meta_q <= '0;
			o_q    <= '0;
		end else begin
			meta_q <= i_d;
			o_q    <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* File: src/bsm_restore_eng.sv */
//------------------------------------------------------------
// Purpose: Factory restore run with time allowance
// Assumes: Flash sequencer pulses i_flash_done when finished
// Notes:   Timeout ends the run without clearing pending state
//------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module bsm_restore_eng #(
	parameter int unsigned LIMIT = bsm_pkg::RESTORE_CYC
) (
	input  wire logic    i_clk,
	input  wire logic    i_sys_rst,
	input  wire logic    i_flash_done,
	bsm_restore_if.eng   rif
);
	import bsm_pkg::*;
	localparam int CW = $clog2(LIMIT + 1);

	logic [CW-1:0] cnt_q;
	logic          limit_hit;
	logic          finish;
	logic          accept;

	assign limit_hit = cnt_q == CW'(LIMIT - 1);
	assign finish    = rif.busy && !rif.abort && (i_flash_done || limit_hit);
	assign accept    = rif.start && !rif.busy;

	// Run state, allowance counter and outcome
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rif.busy     <= 1'b0;
			rif.done     <= 1'b0;
			rif.timeout  <= 1'b0;
			rif.run_kind <= RESTORE_NONE;
			cnt_q        <= '0;
		end else begin
			rif.done <= finish;
			if (rif.abort) begin
				rif.busy <= 1'b0;
			end else if (accept) begin
				rif.busy     <= 1'b1;
				rif.run_kind <= rif.kind;
				rif.timeout  <= 1'b0;
				cnt_q        <= '0;
			end else if (finish) begin
				rif.busy    <= 1'b0;
				rif.timeout <= !i_flash_done;
			end else if (rif.busy) begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	restore_kind_a: assert property (accept && !rif.abort |=> rif.busy && rif.run_kind == $past(rif.kind)) else $error("restore kind not taken");
	restore_limit_a: assert property (rif.busy && limit_hit && !i_flash_done && !rif.abort |=> !rif.busy && rif.timeout && rif.done) else $error("restore allowance not enforced");
endmodule
`default_nettype wire

/* File: src/bsm_boot_select.sv */
//------------------------------------------------------------
// Purpose: Power-up strap sensing and boot flow selection
// Assumes: 125 MHz clock, straps held stable around reset release
// Notes:   Strap code order is {pin2, pin1, pin0}
//------------------------------------------------------------
//------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module bsm_boot_select #(
	parameter int unsigned BREAK_CYCLES   = bsm_pkg::BREAK_CYC,
	parameter int unsigned RESTORE_CYCLES = bsm_pkg::RESTORE_CYC
) (
	input  wire logic                           i_clk,
	input  wire logic                           i_sys_rst,
	input  wire logic                           i_chip_reset_active_low_n,
	input  wire logic [bsm_pkg::STRAP_W-1:0]    i_boot_strap_pins,
	input  wire logic                           i_uart_rx,
	input  wire logic                           i_restore_pending,
	input  wire bsm_pkg::bsm_restore_e          i_restore_setting,
	input  wire logic                           i_restore_done,
	input  wire logic                           i_host_flash_req,
	input  wire logic [bsm_pkg::SECTOR_W-1:0]   i_host_flash_sector,
	output logic                                o_core_reset_q,
	output bsm_pkg::bsm_flow_e                  o_boot_flow_q,
	output logic      [bsm_pkg::STRAP_W-1:0]    o_strap_code_q,
	output logic                                o_jtag_four_wire_q,
	output logic                                o_swd_two_wire_q,
	output logic                                o_first_serial_port_load_q,
	output logic                                o_strap2_free_q,
	output logic                                o_restore_busy_q,
	output bsm_pkg::bsm_restore_e               o_restore_kind_q,
	output logic                                o_restore_timeout_q,
	output logic                                o_restore_pending_q,
	output logic                                o_host_flash_grant_q,
	output logic                                o_host_flash_deny_q
);
	import bsm_pkg::*;

	//------------------------------------------------------------
	// Declarations
	//------------------------------------------------------------
	localparam int SYNC_W = STRAP_W + 2;
	// One counter times both the strap settle and the break check
	localparam int unsigned CNT_MAX = (BREAK_CYCLES > STRAP_SETTLE_CYC) ?
		BREAK_CYCLES : STRAP_SETTLE_CYC;
	localparam int CNT_W  = $clog2(CNT_MAX + 1);

	typedef enum logic [2:0] {
		ST_OFF,
		ST_SETTLE,
		ST_DECODE,
		ST_BREAK,
		ST_RESTORE,
		ST_LOAD,
		ST_RUN
	} bsm_state_e;

	bsm_state_e           st_q, st_d;
	logic [CNT_W-1:0]     cnt_q, cnt_d;
	logic [STRAP_W-1:0]   strap_d;
	bsm_flow_e            flow_d;
	logic [SYNC_W-1:0]    pins_s;
	logic [STRAP_W-1:0]   strap_s;
	logic                 rx_s;
	logic                 rst_ok;
	logic                 code_serial;
	logic                 code_two;
	logic                 code_break;
	logic                 code_restore;
	logic                 restore_on;
	logic                 go_restore;
	logic                 settle_end;
	logic                 break_end;
	logic                 hit_factory;

	bsm_restore_if rif ();

	//------------------------------------------------------------
	// Pin synchronisers
	//------------------------------------------------------------
	bsm_sync #(
		.W(SYNC_W)
	) u_sync (
		.i_clk    (i_clk),
		.i_sys_rst(i_sys_rst),
		.i_d      ({i_chip_reset_active_low_n, i_uart_rx, i_boot_strap_pins}),
		.o_q      (pins_s)
	);

	// Split synchronised levels
	assign strap_s = pins_s[STRAP_W-1:0];
	assign rx_s    = pins_s[STRAP_W];
	assign rst_ok  = pins_s[STRAP_W+1];

	//------------------------------------------------------------
	// Decoding of the stored code
	//------------------------------------------------------------
	// Decode uses the stored value only
	assign code_serial  = o_strap_code_q == SERIAL_LOAD_CODE;
	assign code_two     = o_strap_code_q == RUN_TWO_WIRE_CODE;
	assign code_break   = o_strap_code_q == BREAK_QUALIFIED_LOAD_CODE;
	assign code_restore = o_strap_code_q == FACTORY_RESTORE_CODE;
	assign restore_on   = i_restore_setting != RESTORE_NONE;
	assign settle_end   = cnt_q == CNT_W'(STRAP_SETTLE_CYC - 1);
	assign break_end    = cnt_q == CNT_W'(BREAK_CYCLES - 1);

	// Restore start: pending run first, then strap request
	assign go_restore = st_q == ST_DECODE && rst_ok &&
		(i_restore_pending || (code_restore && restore_on));

	// Restore engine requests
	assign rif.start = go_restore;
	assign rif.abort = !rst_ok;
	assign rif.kind  = i_restore_pending ? RESTORE_IMAGE_PARAMS : i_restore_setting;

	// Factory sector match
	assign hit_factory = i_host_flash_sector == FACTORY_SECTOR;

	//------------------------------------------------------------
	// Boot sequencer next state
	//------------------------------------------------------------
	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q + 1'b1;
		strap_d = o_strap_code_q;
		flow_d  = o_boot_flow_q;
		if (!rst_ok) begin
			// Shutdown while the reset line is low
			st_d   = ST_OFF;
			cnt_d  = '0;
			flow_d = FLOW_HOLD;
		end else begin
			case (st_q)
				ST_OFF: begin
					// Rising reset line starts a fresh boot
					st_d  = ST_SETTLE;
					cnt_d = '0;
				end
				ST_SETTLE: begin
					if (settle_end) begin
						strap_d = strap_s;
						st_d    = ST_DECODE;
					end
				end
				ST_DECODE: begin
					cnt_d = '0;
					if (go_restore) begin
						st_d   = ST_RESTORE;
						flow_d = FLOW_RESTORE;
					end else if (code_serial) begin
						st_d   = ST_LOAD;
						flow_d = FLOW_SERIAL_LOAD;
					end else if (code_two) begin
						st_d   = ST_RUN;
						flow_d = FLOW_RUN_TWO_WIRE;
					end else if (code_break) begin
						st_d = ST_BREAK;
					end else begin
						// Four-wire code, restore with none set, unlisted codes
						st_d   = ST_RUN;
						flow_d = FLOW_RUN_FOUR_WIRE;
					end
				end
				ST_BREAK: begin
					if (rx_s) begin
						st_d   = ST_RUN;
						flow_d = FLOW_RUN_FOUR_WIRE;
					end else if (break_end) begin
						st_d   = ST_LOAD;
						flow_d = FLOW_SERIAL_LOAD;
					end
				end
				ST_RESTORE: begin
					cnt_d = cnt_q;
					if (rif.done) begin
						st_d   = ST_RUN;
						flow_d = FLOW_RUN_FOUR_WIRE;
					end
				end
				ST_LOAD: begin
					// Waits until the next reset
					cnt_d = cnt_q;
				end
				ST_RUN: begin
					cnt_d = cnt_q;
				end
				default: begin
					st_d   = ST_OFF;
					cnt_d  = '0;
					flow_d = FLOW_HOLD;
				end
			endcase
		end
	end

	//------------------------------------------------------------
	// Sequencer registers
	//------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_q           <= ST_OFF;
			cnt_q          <= '0;
			o_strap_code_q <= STRAP_RESET_VAL;
			o_boot_flow_q  <= FLOW_HOLD;
		end else begin
			st_q           <= st_d;
			cnt_q          <= cnt_d;
			o_strap_code_q <= strap_d;
			o_boot_flow_q  <= flow_d;
		end
	end

	//------------------------------------------------------------
	// Pin mapping outputs from the next flow
	//------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_core_reset_q             <= 1'b1;
			o_jtag_four_wire_q         <= 1'b0;
			o_swd_two_wire_q           <= 1'b0;
			o_first_serial_port_load_q <= 1'b0;
			o_strap2_free_q            <= 1'b0;
		end else begin
			o_core_reset_q             <= flow_d == FLOW_HOLD || flow_d == FLOW_RESTORE;
			o_jtag_four_wire_q         <= flow_d == FLOW_SERIAL_LOAD ||
				flow_d == FLOW_RUN_FOUR_WIRE;
			o_swd_two_wire_q           <= flow_d == FLOW_RUN_TWO_WIRE;
			o_first_serial_port_load_q <= flow_d == FLOW_SERIAL_LOAD;
			// Only pin 2 is ever released; pins 0 and 1 stay dedicated
			o_strap2_free_q            <= st_d == ST_RUN;
		end
	end

	//------------------------------------------------------------
	// Restore engine and pending flag
	//------------------------------------------------------------
	bsm_restore_eng #(
		.LIMIT(RESTORE_CYCLES)
	) u_restore (
		.i_clk       (i_clk),
		.i_sys_rst   (i_sys_rst),
		.i_flash_done(i_restore_done),
		.rif         (rif)
	);

	// Engine state is already registered
	assign o_restore_busy_q    = rif.busy;
	assign o_restore_kind_q    = rif.run_kind;
	assign o_restore_timeout_q = rif.timeout;

	// Pending stays set until a run completes; a new start wins
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_restore_pending_q <= 1'b0;
		end else if (go_restore) begin
			o_restore_pending_q <= 1'b1;
		end else if (rif.done && !rif.timeout) begin
			o_restore_pending_q <= 1'b0;
		end
	end

	//------------------------------------------------------------
	// Host access guard for the factory sector
	//------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_host_flash_grant_q <= 1'b0;
			o_host_flash_deny_q  <= 1'b0;
		end else begin
			o_host_flash_grant_q <= i_host_flash_req && !hit_factory;
			o_host_flash_deny_q  <= i_host_flash_req && hit_factory;
		end
	end

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	strap_latch_a: assert property (st_q == ST_SETTLE && settle_end && rst_ok |=> o_strap_code_q == $past(strap_s) && st_q == ST_DECODE && o_core_reset_q) else $error("strap code not stored before release");
	release_order_a: assert property ($fell(o_core_reset_q) |-> $past(st_q) inside {ST_DECODE, ST_BREAK, ST_RESTORE}) else $error("core released without decode");
	code_hold_a: assert property (st_q inside {ST_LOAD, ST_RUN} && rst_ok |=> $stable(o_strap_code_q)) else $error("stored code changed");
	serial_load_a: assert property (st_q == ST_DECODE && rst_ok && !go_restore && code_serial |=> st_q == ST_LOAD ##1 o_jtag_four_wire_q && o_first_serial_port_load_q && !o_core_reset_q) else $error("serial load flow wrong");
	two_wire_a: assert property (st_q == ST_DECODE && rst_ok && !go_restore && code_two |=> o_swd_two_wire_q && !o_jtag_four_wire_q && o_strap2_free_q) else $error("two-wire flow wrong");
	fallback_a: assert property (st_q == ST_DECODE && rst_ok && !go_restore && (o_strap_code_q == RUN_FOUR_WIRE_CODE || o_strap_code_q[2] && o_strap_code_q != SERIAL_LOAD_CODE) |=> o_boot_flow_q == FLOW_RUN_FOUR_WIRE && o_jtag_four_wire_q) else $error("four-wire flow wrong");
	break_idle_a: assert property (st_q == ST_BREAK && rst_ok && rx_s |=> o_boot_flow_q == FLOW_RUN_FOUR_WIRE && o_jtag_four_wire_q) else $error("idle line did not run");
	restore_start_a: assert property (st_q == ST_DECODE && rst_ok && code_restore && restore_on |=> rif.busy && st_q == ST_RESTORE && o_restore_pending_q) else $error("restore not started");
	resume_a: assert property (st_q == ST_DECODE && rst_ok && i_restore_pending |=> rif.busy && rif.run_kind == RESTORE_IMAGE_PARAMS) else $error("pending restore not resumed");
	guard_a: assert property (i_host_flash_req && hit_factory |=> o_host_flash_deny_q && !o_host_flash_grant_q) else $error("factory sector reached");
	shutdown_a: assert property (!rst_ok |=> st_q == ST_OFF ##1 o_core_reset_q && !o_strap2_free_q) else $error("shutdown not entered");
endmodule
`default_nettype wire

/* File: tb/bsm_board_model.sv */
// Purpose: Board straps, reset pin, serial host and flash sequencer
// Assumes: Bench and model change pins at the falling clock edge
// Notes:   A done delay of zero means the flash never finishes
`timescale 1ns/1ps
`default_nettype none
module bsm_board_model (
	input  wire logic       i_clk,
	input  wire logic [2:0] i_code,
	input  wire logic       i_pin_up,
	input  wire logic       i_brk,
	input  wire logic [7:0] i_dly,
	input  wire logic       i_strap2_free,
	input  wire logic       i_busy,
	output logic      [2:0] o_pins,
	output logic            o_rst_n,
	output logic            o_rx,
	output logic            o_done
);
	logic [7:0] cnt_q  = 8'h00;
	logic       busy_q = 1'b0;
	logic       tog_q  = 1'b0;
	logic       done_q = 1'b0;
	// Freed pin 2 is reused as a toggling output, never read back
	assign o_pins  = {i_strap2_free ? tog_q : i_code[2], i_code[1:0]};
	// New straps only count with a fresh rise of the reset pin
	assign o_rst_n = i_pin_up;
	// Break holds the receive line low, idle is high
	assign o_rx    = ~i_brk;
	assign o_done  = done_q;
	// Flash sequencer answers a restore after i_dly cycles
	always @(negedge i_clk) begin
		tog_q  <= ~tog_q;
		busy_q <= i_busy;
		done_q <= 1'b0;
		if (i_busy && !busy_q)
			cnt_q <= 8'h01;
		else if (cnt_q != 8'h00)
			cnt_q <= cnt_q + 8'h01;
		if (cnt_q != 8'h00 && cnt_q == i_dly) begin
			done_q <= 1'b1;
			cnt_q  <= 8'h00;
		end
	end
endmodule
`default_nettype wire

/* File: tb/boot_strap_mode_select_bench.sv */
// Purpose: Self-checking bench of the boot mode select
// Assumes: Inputs change at the falling edge, 125 MHz clock
// Notes:   Short break and restore counts keep the run brief
`timescale 1ns/1ps
`default_nettype none
module boot_strap_mode_select_bench;
	import bsm_pkg::*;
	//------------------------------------------------------------
	// Signals
	//------------------------------------------------------------
	logic         i_clk    = 1'b0;
	logic         i_sys_rst = 1'b1;
	logic         pin_up   = 1'b0;
	logic         brk      = 1'b0;
	logic         pend     = 1'b0;
	logic         req      = 1'b0;
	logic         saw_busy = 1'b0;
	logic [2:0]   code_drv = 3'h0;
	logic [7:0]   dly      = 8'h00;
	logic [7:0]   sector   = 8'h00;
	logic [31:0]  lf       = 32'h225a_fc94;
	bsm_restore_e setting  = RESTORE_NONE;
	bsm_restore_e kseen    = RESTORE_NONE;
	logic [2:0]   pins, scode;
	logic         rst_n, rx, done, core_rst, jtag4, swd2, ld, s2free;
	logic         busy, tmo, pend_q, grant, deny;
	bsm_flow_e    flow;
	bsm_restore_e kind;
	int           mismatches = 0;
	int           n_checks   = 0;
	int           cycles     = 0;
	//------------------------------------------------------------
	// Clock, instances and watchdog
	//------------------------------------------------------------
	initial forever #4 i_clk = ~i_clk;
	bsm_boot_select #(.BREAK_CYCLES(20), .RESTORE_CYCLES(50)) bsm_boot_select_inst (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_chip_reset_active_low_n(rst_n),
		.i_boot_strap_pins(pins), .i_uart_rx(rx), .i_restore_pending(pend),
		.i_restore_setting(setting), .i_restore_done(done), .i_host_flash_req(req),
		.i_host_flash_sector(sector), .o_core_reset_q(core_rst), .o_boot_flow_q(flow),
		.o_strap_code_q(scode), .o_jtag_four_wire_q(jtag4), .o_swd_two_wire_q(swd2),
		.o_first_serial_port_load_q(ld), .o_strap2_free_q(s2free),
		.o_restore_busy_q(busy), .o_restore_kind_q(kind), .o_restore_timeout_q(tmo),
		.o_restore_pending_q(pend_q), .o_host_flash_grant_q(grant),
		.o_host_flash_deny_q(deny));
	bsm_board_model bsm_board_model_inst (
		.i_clk(i_clk), .i_code(code_drv), .i_pin_up(pin_up), .i_brk(brk), .i_dly(dly),
		.i_strap2_free(s2free), .i_busy(busy), .o_pins(pins), .o_rst_n(rst_n),
		.o_rx(rx), .o_done(done));
	// Restore seen: note its kind, the stored pending flag is taken over
	always @(negedge i_clk) begin
		if (busy === 1'b1) begin
			saw_busy <= 1'b1;
			kseen    <= kind;
			pend     <= 1'b0;
		end
	end
	// Hang guard
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			test_done();
		end
	end
	//------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic report(input logic [31:0] a, input logic [31:0] e);
		mismatches++;
		$display("[FAIL] %0t got %h exp %h", $time, a, e);
	endtask
	task automatic chk1(input logic a, input logic e);
		n_checks++;
		if (a !== e) report(a, e);
	endtask
	task automatic chk3(input logic [2:0] a, input logic [2:0] e);
		n_checks++;
		if (a !== e) report(a, e);
	endtask
	task automatic chkf(input bsm_flow_e a, input bsm_flow_e e);
		n_checks++;
		if (a !== e) report(a, e);
	endtask
	task automatic chkk(input bsm_restore_e a, input bsm_restore_e e);
		n_checks++;
		if (a !== e) report(a, e);
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic bsm_flow_e exp_flow(input logic [2:0] c, input logic b);
		if (c == SERIAL_LOAD_CODE || (c == BREAK_QUALIFIED_LOAD_CODE && b))
			return FLOW_SERIAL_LOAD;
		if (c == RUN_TWO_WIRE_CODE)
			return FLOW_RUN_TWO_WIRE;
		return FLOW_RUN_FOUR_WIRE;
	endfunction
	// Shutdown, new straps, fresh boot, then straps change after the latch
	task automatic boot(input logic [2:0] c, input logic b, input bsm_restore_e s,
			input logic [7:0] d);
		bsm_flow_e e;
		logic      eb;
		logic      pb;
		int        n;
		e = exp_flow(c, b);
		pb = pend;
		eb = pend || (c == FACTORY_RESTORE_CODE && s != RESTORE_NONE);
		@(negedge i_clk) pin_up = 1'b0;
		repeat (6) @(negedge i_clk);
		chk1(core_rst, 1'b1);
		chk1(jtag4 | swd2 | ld, 1'b0);
		code_drv = c;
		brk = b;
		setting = s;
		dly = d;
		saw_busy = 1'b0;
		@(negedge i_clk) pin_up = 1'b1;
		repeat (100) @(negedge i_clk);
		chkf(flow, FLOW_HOLD);
		n = 0;
		while (n < 600 && tmo !== 1'b1 && !(flow inside {FLOW_SERIAL_LOAD,
				FLOW_RUN_TWO_WIRE, FLOW_RUN_FOUR_WIRE})) begin
			@(negedge i_clk);
			n++;
		end
		code_drv = ~c;
		repeat (10) @(negedge i_clk);
		chk3(scode, c);
		chk1(saw_busy, eb);
		if (eb) chkk(kseen, pb ? RESTORE_IMAGE_PARAMS : s);
		if (d == 8'h00 && eb) begin
			chk1(tmo, 1'b1);
			chk1(pend_q, 1'b1);
		end else begin
			chkf(flow, e);
			chk1(jtag4, e != FLOW_RUN_TWO_WIRE);
			chk1(swd2, e == FLOW_RUN_TWO_WIRE);
			chk1(ld, e == FLOW_SERIAL_LOAD);
			chk1(s2free, e != FLOW_SERIAL_LOAD);
			chk1(core_rst, 1'b0);
			chk1(pend_q, 1'b0);
		end
		code_drv = c;
	endtask
	//------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------
	initial begin
		repeat (12) @(negedge i_clk);
		i_sys_rst = 1'b0;
		for (int c = 0; c < 8; c++) boot(3'(c), 1'b0, RESTORE_NONE, 8'h00);
		boot(BREAK_QUALIFIED_LOAD_CODE, 1'b1, RESTORE_NONE, 8'h00);
		repeat (6) begin
			lf = lfsr(lf);
			boot(lf[2:0], lf[5], RESTORE_NONE, 8'h00);
		end
		boot(FACTORY_RESTORE_CODE, 1'b0, RESTORE_PARAMS, 8'h0a);
		boot(FACTORY_RESTORE_CODE, 1'b1, RESTORE_IMAGE_PARAMS, 8'h01);
		pend = 1'b1;
		boot(RUN_FOUR_WIRE_CODE, 1'b0, RESTORE_NONE, 8'h05);
		// Host accesses back to back, factory sector among them
		for (int i = 0; i < 40; i++) begin
			@(negedge i_clk);
			if (i > 0) begin
				chk1(grant, req && sector != FACTORY_SECTOR);
				chk1(deny, req && sector == FACTORY_SECTOR);
			end
			lf = lfsr(lf);
			req = lf[8] | lf[9];
			sector = (i % 5 == 1) ? FACTORY_SECTOR : lf[7:0];
		end
		req = 1'b0;
		boot(FACTORY_RESTORE_CODE, 1'b0, RESTORE_PARAMS, 8'h00);
		// Mid-run system reset, then a fresh boot
		@(negedge i_clk) i_sys_rst = 1'b1;
		repeat (3) @(negedge i_clk);
		chk1(core_rst, 1'b1);
		chk3(scode, STRAP_RESET_VAL);
		i_sys_rst = 1'b0;
		boot(RUN_TWO_WIRE_CODE, 1'b0, RESTORE_NONE, 8'h00);
		test_done();
	end
endmodule
`default_nettype wire
